// *** design/load_store_bitfield_branch_exec.sv ***
// Overview of operation
// - Unsigned byte/half loads zero-extend to 32 bits; plain load moves a word.
// - Signed sizes only on loads, sign-extended; stores must not use them.
// - Address is base plus offset register shifted left 0 to 3.
// - Compare subtracts second operand, sets flags, writes no register.
// - Compare-negative adds second operand, sets flags, writes no register.
// - Both compares set N, Z, C, V like flag-setting add/subtract.
// - Bitfield clear zeroes width bits from low position, rest kept.
// - Bitfield insert copies width source bits from bit 0 into position.
// - Extend ops first rotate source right by 0, 8, 16 or 24.
// - Then take low byte or halfword, sign or zero extend.
// - Bitfield/extend keep flags, refuse stack pointer and PC operands.
// - Indirect branch target is register value with bit 0 cleared.
// - Indirect branch with bit 0 clear raises usage fault, no branch.
// - Branch-with-link forms write next instruction address to link register.
// - Immediate branch reach 16 MB; conditional outside block only 1 MB.
// - Zero-test branches: low registers, forward 4 to 130, not in block.
// - Zero-test taken on zero, nonzero on nonzero; flags unchanged.
`timescale 1ns/1ps
`default_nettype none

module load_store_bitfield_branch_exec (
	// Clock and reset
	input  wire logic                    i_clock,
	input  wire logic                    i_reset_n,
	// Instruction side
	input  wire logic                    i_valid,
	input  wire exec_pkg::exec_op_t      i_op,
	input  wire exec_pkg::mem_size_t     i_size,
	input  wire logic [31:0]             i_pc,
	input  wire logic [3:0]              i_rd_index,
	input  wire logic [3:0]              i_base_index,
	input  wire logic [3:0]              i_second_index,
	input  wire logic [31:0]             i_base_register,
	input  wire logic [31:0]             i_offset_or_target_register,
	input  wire logic [31:0]             i_second_operand,
	input  wire logic [31:0]             i_dest_value,
	input  wire logic [1:0]              i_left_shift_amount,
	input  wire logic [4:0]              i_lsb,
	input  wire logic [5:0]              i_width,
	input  wire logic [1:0]              i_rotate_sel,
	input  wire logic signed [31:0]      i_branch_offset,
	input  wire logic                    i_conditional,
	input  wire logic                    i_in_cond_block,
	// Data memory side
	input  wire logic [31:0]             i_mem_rdata,
	output logic                         o_mem_req,
	output logic                         o_mem_write,
	output logic [31:0]                  o_mem_addr,
	output logic [31:0]                  o_mem_wdata,
	output logic [3:0]                   o_mem_strobe,
	// Results
	output logic                         o_wb_valid,
	output logic [3:0]                   o_wb_index,
	output logic [31:0]                  o_wb_data,
	output logic                         o_link_valid,
	output logic [31:0]                  o_link_register,
	output logic                         o_branch_taken,
	output logic [31:0]                  o_branch_target,
	output logic [3:0]                   o_flags_nzcv,
	output logic                         o_usage_fault_a,
	output logic                         o_illegal
);

	// ***************************************************************
	// Stage registers: one instruction per cycle, load data next cycle
	// ***************************************************************
	logic [31:0]          addr_nxt;
	logic [32:0]          alu_sum;
	logic [31:0]          alu_b;
	logic                 alu_sub;
	logic [31:0]          field_mask;
	logic [31:0]          ext_result;
	logic [31:0]          load_result;
	logic [31:0]          load_shifted;
	logic                 illegal_nxt;
	logic                 is_ext;
	logic                 is_ld;
	logic                 is_st;
	logic                 is_cmp;
	logic                 is_bf;
	logic                 is_zt;
	logic                 is_ind;
	logic                 is_imm_br;
	logic signed [31:0]   reach;
	logic [31:0]          next_pc;
	logic                 load_pending_r;
	logic [3:0]           load_index_r;
	exec_pkg::mem_size_t  load_size_r;
	logic [1:0]           load_lane_r;

	// Operation classes
	assign is_ld     = i_valid && (i_op == exec_pkg::load_register_op);
	assign is_st     = i_valid && (i_op == exec_pkg::store_register_op);
	assign is_cmp    = i_valid && (i_op == exec_pkg::compare_op
	                   || i_op == exec_pkg::compare_negative_op);
	assign is_bf     = i_valid && (i_op == exec_pkg::bitfield_clear_op
	                   || i_op == exec_pkg::bitfield_insert_op);
	assign is_ext    = i_valid && (i_op >= exec_pkg::signed_byte_extend_op)
	                   && (i_op <= exec_pkg::unsigned_half_extend_op);
	assign is_zt     = i_valid && (i_op == exec_pkg::branch_if_zero_op
	                   || i_op == exec_pkg::branch_if_nonzero_op);
	assign is_ind    = i_valid && (i_op == exec_pkg::register_indirect_branch_op
	                   || i_op == exec_pkg::indirect_branch_with_link_op);
	assign is_imm_br = i_valid && (i_op == exec_pkg::branch_op
	                   || i_op == exec_pkg::branch_with_link_op);
	assign next_pc   = i_pc + exec_pkg::INSN_LEN;

	// Base plus scaled offset
	assign addr_nxt = i_base_register + (i_offset_or_target_register << i_left_shift_amount);

	// Shared adder: compare subtracts, compare-negative adds
	assign alu_sub = (i_op == exec_pkg::compare_op);
	assign alu_b   = alu_sub ? ~i_second_operand : i_second_operand;
	assign alu_sum = {1'b0, i_base_register} + {1'b0, alu_b} + {32'h0, alu_sub};

	// Field mask; 33-bit math avoids overflow at width 32
	always_comb begin
		logic [32:0] ones;
		ones       = 33'h0;
		ones       = (33'h1 << i_width) - 33'h1;
		field_mask = ones[31:0] << i_lsb;
	end

	// Rotate-and-extend for the extend ops
	field_extend u_ext (
		.i_value     (i_offset_or_target_register),
		.i_rot_bytes (i_rotate_sel),
		.i_half      (i_op == exec_pkg::signed_half_extend_op
		              || i_op == exec_pkg::unsigned_half_extend_op),
		.i_signed    (i_op == exec_pkg::signed_byte_extend_op
		              || i_op == exec_pkg::signed_half_extend_op),
		.o_result    (ext_result)
	);

	// Load data: the byte lane comes down to bit 0 before extension
	field_extend u_load (
		.i_value     (i_mem_rdata),
		.i_rot_bytes (load_lane_r),
		.i_half      (load_size_r == exec_pkg::size_uhalf
		              || load_size_r == exec_pkg::size_shalf),
		.i_signed    (load_size_r == exec_pkg::size_sbyte
		              || load_size_r == exec_pkg::size_shalf),
		.o_result    (load_shifted)
	);
	assign load_result = (load_size_r == exec_pkg::size_word_t_w)
	                     ? i_mem_rdata : load_shifted;

	// Reach for immediate branches depends on the block context
	assign reach = (i_op == exec_pkg::branch_op && i_conditional && !i_in_cond_block)
	               ? exec_pkg::REACH_NEAR : exec_pkg::REACH_FAR;

	// ***************************************************************
	// Refused encodings; operand checks guard against later misuse
	// ***************************************************************
	always_comb begin
		illegal_nxt = 1'b0;
		if (is_st && (i_size == exec_pkg::size_sbyte || i_size == exec_pkg::size_shalf)) begin
			illegal_nxt = 1'b1;
		end
		if (is_cmp && (i_base_index == exec_pkg::PC_INDEX
		    || i_second_index == exec_pkg::SP_INDEX
		    || i_second_index == exec_pkg::PC_INDEX)) begin
			illegal_nxt = 1'b1;
		end
		if (is_bf && ({1'b0, i_width} + {2'h0, i_lsb} > 7'h20 || i_width == 6'h00)) begin
			illegal_nxt = 1'b1;
		end
		if ((is_bf || is_ext) && (i_rd_index >= exec_pkg::SP_INDEX
		    || (i_op != exec_pkg::bitfield_clear_op
		        && i_second_index >= exec_pkg::SP_INDEX))) begin
			illegal_nxt = 1'b1;
		end
		if ((is_ind || i_op == exec_pkg::branch_with_link_op)
		    && (i_conditional != i_in_cond_block) && i_valid) begin
			illegal_nxt = 1'b1;
		end
		if (i_op == exec_pkg::branch_op && i_valid && !i_conditional && i_in_cond_block) begin
			illegal_nxt = 1'b1;
		end
		if (is_imm_br && (i_branch_offset >= reach || i_branch_offset < -reach)) begin
			illegal_nxt = 1'b1;
		end
		if (is_zt && (i_second_index > exec_pkg::LOW_REG_LIMIT || i_in_cond_block
		    || i_branch_offset < $signed(exec_pkg::ZTEST_MIN)
		    || i_branch_offset > $signed(exec_pkg::ZTEST_MAX))) begin
			illegal_nxt = 1'b1;
		end
	end

	// ***************************************************************
	// Memory request, registered one cycle
	// ***************************************************************
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_mem_req    <= 1'b0;
			o_mem_write  <= 1'b0;
			o_mem_addr   <= 32'h0;
			o_mem_wdata  <= 32'h0;
			o_mem_strobe <= 4'h0;
		end else begin
			o_mem_req   <= (is_ld || is_st) && !illegal_nxt;
			o_mem_write <= is_st && !illegal_nxt;
			o_mem_addr  <= addr_nxt;
			// Replicate low data across lanes; strobe picks the lane
			unique case (i_size)
				exec_pkg::size_ubyte, exec_pkg::size_sbyte: begin
					o_mem_wdata  <= {4{i_dest_value[7:0]}};
					o_mem_strobe <= exec_pkg::STB_BYTE << addr_nxt[1:0];
				end
				exec_pkg::size_uhalf, exec_pkg::size_shalf: begin
					o_mem_wdata  <= {2{i_dest_value[15:0]}};
					o_mem_strobe <= exec_pkg::STB_HALF << {addr_nxt[1], 1'b0};
				end
				default: begin
					o_mem_wdata  <= i_dest_value;
					o_mem_strobe <= exec_pkg::STB_WORD;
				end
			endcase
		end
	end

	// Load tracking; data returns in the request cycle, written back at its end
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			load_pending_r <= 1'b0;
			load_index_r   <= 4'h0;
			load_size_r    <= exec_pkg::size_word_t_w;
			load_lane_r    <= 2'h0;
		end else begin
			load_pending_r <= is_ld && !illegal_nxt;
			load_index_r   <= i_rd_index;
			load_size_r    <= i_size;
			load_lane_r    <= addr_nxt[1:0];
		end
	end

	// ***************************************************************
	// Register write-back; compares write nothing
	// ***************************************************************
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wb_valid <= 1'b0;
			o_wb_index <= 4'h0;
			o_wb_data  <= 32'h0;
		end else if (load_pending_r) begin
			o_wb_valid <= 1'b1;
			o_wb_index <= load_index_r;
			o_wb_data  <= load_result;
		end else begin
			o_wb_valid <= (is_bf || is_ext) && !illegal_nxt;
			o_wb_index <= i_rd_index;
			if (i_op == exec_pkg::bitfield_clear_op) begin
				o_wb_data <= i_dest_value & ~field_mask;
			end else if (i_op == exec_pkg::bitfield_insert_op) begin
				o_wb_data <= (i_dest_value & ~field_mask)
				             | ((i_second_operand << i_lsb) & field_mask);
			end else begin
				o_wb_data <= ext_result;
			end
		end
	end

	// Condition flags: only compares touch them
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_flags_nzcv <= 4'h0;
		end else if (is_cmp && !illegal_nxt) begin
			o_flags_nzcv <= {alu_sum[31], alu_sum[31:0] == 32'h0, alu_sum[32],
			                 (i_base_register[31] == alu_b[31])
			                 && (alu_sum[31] != i_base_register[31])};
		end
	end

	// ***************************************************************
	// Branch resolution, link write and usage fault
	// ***************************************************************
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_branch_taken  <= 1'b0;
			o_branch_target <= 32'h0;
			o_link_valid    <= 1'b0;
			o_link_register <= 32'h0;
			o_usage_fault_a <= 1'b0;
			o_illegal       <= 1'b0;
		end else begin
			o_illegal       <= illegal_nxt;
			o_usage_fault_a <= is_ind && !illegal_nxt
			                   && !i_offset_or_target_register[0];
			o_link_register <= next_pc;
			o_link_valid    <= !illegal_nxt
			                   && ((is_ind && i_offset_or_target_register[0]
			                        && i_op == exec_pkg::indirect_branch_with_link_op)
			                       || (i_valid && i_op == exec_pkg::branch_with_link_op));
			if (is_ind) begin
				o_branch_taken  <= !illegal_nxt && i_offset_or_target_register[0];
				o_branch_target <= {i_offset_or_target_register[31:1], 1'b0};
			end else if (is_zt) begin
				o_branch_taken  <= !illegal_nxt && ((i_second_operand == 32'h0)
				                   == (i_op == exec_pkg::branch_if_zero_op));
				o_branch_target <= i_pc + i_branch_offset;
			end else begin
				o_branch_taken  <= is_imm_br && !illegal_nxt;
				o_branch_target <= i_pc + i_branch_offset;
			end
		end
	end

endmodule : load_store_bitfield_branch_exec

`default_nettype wire

// *** design/exec_pkg.sv ***
package exec_pkg;

	// ***************************************************************
	// Operation codes presented on the instruction side
	// ***************************************************************
	typedef enum logic [4:0] {
		op_none_t_nop                   = 5'h00,
		load_register_op                = 5'h01,
		store_register_op               = 5'h02,
		compare_op                      = 5'h03,
		compare_negative_op             = 5'h04,
		bitfield_clear_op               = 5'h05,
		bitfield_insert_op              = 5'h06,
		signed_byte_extend_op           = 5'h07,
		unsigned_byte_extend_op         = 5'h08,
		signed_half_extend_op           = 5'h09,
		unsigned_half_extend_op         = 5'h0a,
		branch_op                       = 5'h0b,
		branch_with_link_op             = 5'h0c,
		register_indirect_branch_op     = 5'h0d,
		indirect_branch_with_link_op    = 5'h0e,
		branch_if_zero_op               = 5'h0f,
		branch_if_nonzero_op            = 5'h10
	} exec_op_t;

	// Access sizes for loads and stores
	typedef enum logic [2:0] {
		size_word_t_w   = 3'h0,
		size_ubyte      = 3'h1,
		size_sbyte      = 3'h2,
		size_uhalf      = 3'h3,
		size_shalf      = 3'h4
	} mem_size_t;

	// ***************************************************************
	// Widths, field positions and limits
	// ***************************************************************
	localparam int unsigned DATA_W        = 32;
	localparam int unsigned REG_IDX_W     = 4;
	localparam logic [3:0]  SP_INDEX      = 4'hd;
	localparam logic [3:0]  LR_INDEX      = 4'he;
	localparam logic [3:0]  PC_INDEX      = 4'hf;
	localparam logic [3:0]  LOW_REG_LIMIT = 4'h7;
	localparam logic [1:0]  SHIFT_MAX     = 2'h3;
	localparam logic [4:0]  BYTE_MSB      = 5'h07;
	localparam logic [4:0]  HALF_MSB      = 5'h0f;
	localparam logic [31:0] INSN_LEN      = 32'h0000_0004;
	// Branch reach, in bytes, signed offsets
	localparam logic signed [31:0] REACH_FAR   = 32'sh0100_0000; // 16 MB
	localparam logic signed [31:0] REACH_NEAR  = 32'sh0010_0000; // 1 MB
	localparam logic [31:0]        ZTEST_MIN   = 32'h0000_0004;
	localparam logic [31:0]        ZTEST_MAX   = 32'h0000_0082;
	localparam logic [3:0]         STB_BYTE    = 4'h1;
	localparam logic [3:0]         STB_HALF    = 4'h3;
	localparam logic [3:0]         STB_WORD    = 4'hf;

endpackage : exec_pkg

// *** design/field_extend.sv ***
`timescale 1ns/1ps
`default_nettype none

// Rotate then extend; shared by extend ops and load data alignment
module field_extend (
	// Source and selection
	input  wire logic [31:0] i_value,
	input  wire logic [1:0]  i_rot_bytes,
	input  wire logic        i_half,
	input  wire logic        i_signed,
	// Result
	output logic      [31:0] o_result
);

	logic [31:0] rotated;
	logic [4:0]  rot_bits;

	// ***************************************************************
	// Rotate right by whole bytes, then pick the low field
	// ***************************************************************
	assign rot_bits = {i_rot_bytes, 3'h0};
	assign rotated  = (i_value >> rot_bits) | (i_value << (6'h20 - {1'b0, rot_bits}));

	// Extraction after rotation, sign or zero fill
	always_comb begin
		if (i_half) begin
			o_result = {{16{i_signed & rotated[exec_pkg::HALF_MSB]}}, rotated[15:0]};
		end else begin
			o_result = {{24{i_signed & rotated[exec_pkg::BYTE_MSB]}}, rotated[7:0]};
		end
	end

endmodule : field_extend

`default_nettype wire

// *** verification/exec_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module exec_monitor (
	// Clock, reset and instruction side
	input wire logic                i_clock, i_reset_n, i_valid,
	input wire exec_pkg::exec_op_t  i_op,
	input wire exec_pkg::mem_size_t i_size,
	input wire logic [31:0]         i_pc, i_base_register, i_offset_or_target_register,
	input wire logic [31:0]         i_second_operand,
	input wire logic [3:0]          i_base_index, i_second_index,
	input wire logic [1:0]          i_left_shift_amount,
	input wire logic                i_conditional, i_in_cond_block,
	// Results
	input wire logic                o_mem_req, o_link_valid, o_branch_taken,
	input wire logic                o_usage_fault_a, o_illegal,
	input wire logic [31:0]         o_mem_addr, o_link_register, o_branch_target,
	input wire logic [3:0]          o_flags_nzcv
);
	// Flag-setting add or subtract; carry means no borrow
	function automatic logic [3:0] nzcv(input logic [31:0] a, b, input logic sub);
		logic [31:0] bb;
		logic [32:0] s;
		bb = sub ? ~b : b;
		s = {1'b0, a} + {1'b0, bb} + {32'h0, sub};
		return {s[31], s[31:0] == 32'h0, s[32], a[31] == bb[31] && s[31] != a[31]};
	endfunction : nzcv
	// Qualifiers: a legal compare, an indirect branch outside any block
	wire cmp_ok = i_valid && i_base_index != exec_pkg::PC_INDEX
		&& i_second_index != exec_pkg::SP_INDEX && i_second_index != exec_pkg::PC_INDEX;
	wire ind_ok = i_valid && !i_conditional && !i_in_cond_block && (i_op inside
		{exec_pkg::register_indirect_branch_op, exec_pkg::indirect_branch_with_link_op});
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	a_cmp_flags:
	assert property (cmp_ok && i_op == exec_pkg::compare_op |=> o_flags_nzcv ==
		nzcv($past(i_base_register), $past(i_second_operand), 1'b1)) else $error("cmp flags");
	a_cmn_flags:
	assert property (cmp_ok && i_op == exec_pkg::compare_negative_op |=> o_flags_nzcv ==
		nzcv($past(i_base_register), $past(i_second_operand), 1'b0)) else $error("cmn flags");
	a_flags_kept:
	assert property (i_valid && (i_op inside {[exec_pkg::bitfield_clear_op :
		exec_pkg::unsigned_half_extend_op], exec_pkg::branch_if_zero_op,
		exec_pkg::branch_if_nonzero_op}) |=> $stable(o_flags_nzcv)) else $error("flags moved");
	a_load_addr:
	assert property (i_valid && i_op == exec_pkg::load_register_op |=> o_mem_req && o_mem_addr ==
		$past(i_base_register) + ($past(i_offset_or_target_register) << $past(i_left_shift_amount)))
		else $error("load address");
	a_signed_store:
	assert property (i_valid && i_op == exec_pkg::store_register_op && (i_size inside
		{exec_pkg::size_sbyte, exec_pkg::size_shalf}) |=> o_illegal && !o_mem_req)
		else $error("signed store taken");
	a_ind_fault:
	assert property (ind_ok && !i_offset_or_target_register[0]
		|=> o_usage_fault_a && !o_branch_taken && !o_link_valid) else $error("no usage fault");
	a_ind_target:
	assert property (ind_ok && i_offset_or_target_register[0] |=> o_branch_taken &&
		o_branch_target == ($past(i_offset_or_target_register) & 32'hffff_fffe))
		else $error("indirect target");
	a_link_addr:
	assert property (ind_ok && i_offset_or_target_register[0] &&
		i_op == exec_pkg::indirect_branch_with_link_op
		|=> o_link_valid && o_link_register == $past(i_pc) + 32'h4) else $error("link value");
endmodule : exec_monitor
bind load_store_bitfield_branch_exec exec_monitor u_monitor (.*);
`default_nettype wire

// *** verification/data_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
	// Access from the execution block
	input  wire logic        i_clock, i_req, i_write,
	input  wire logic [31:0] i_addr, i_wdata,
	input  wire logic [3:0]  i_strobe,
	// Read word
	output logic      [31:0] o_rdata
);
	logic [31:0] mem [16];
	logic [31:0] junk_r = 32'h5a5a_a5a5;
	// Outside a read the bus moves every cycle, so stale data never matches
	assign o_rdata = (i_req && !i_write) ? mem[i_addr[5:2]] : junk_r;
	// Writes land lane by lane at the end of the request cycle
	always @(posedge i_clock) begin
		junk_r <= ~junk_r;
		if (i_req && i_write)
			for (int k = 0; k < 4; k++)
				if (i_strobe[k])
					mem[i_addr[5:2]][8*k +: 8] <= i_wdata[8*k +: 8];
	end
endmodule : data_mem_model
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ****************
	// Signals and parts
	// ****************
	logic i_clock = 1'b0, i_reset_n = 1'b0, i_valid = 1'b0;
	exec_pkg::exec_op_t  i_op = exec_pkg::op_none_t_nop;
	exec_pkg::mem_size_t i_size = exec_pkg::size_word_t_w;
	logic [31:0] i_pc = 32'h0, i_base_register = 32'h0, i_offset_or_target_register = 32'h1;
	logic [31:0] i_second_operand = 32'h0, i_dest_value = 32'h0, i_mem_rdata;
	logic signed [31:0] i_branch_offset = 32'sh0;
	logic [3:0]  i_rd_index = 4'h4, i_base_index = 4'h1, i_second_index = 4'h2;
	logic [1:0]  i_left_shift_amount = 2'h0, i_rotate_sel = 2'h0;
	logic [4:0]  i_lsb = 5'h0;
	logic [5:0]  i_width = 6'h1;
	logic        i_conditional = 1'b0, i_in_cond_block = 1'b0;
	logic o_mem_req, o_mem_write, o_wb_valid, o_link_valid, o_branch_taken, o_usage_fault_a;
	logic o_illegal;
	logic [31:0] o_mem_addr, o_mem_wdata, o_wb_data, o_link_register, o_branch_target;
	logic [3:0]  o_mem_strobe, o_wb_index, o_flags_nzcv;
	int n_errors = 0, n_tests = 0;
	always #20 i_clock = ~i_clock;
	load_store_bitfield_branch_exec u_dut (.*);
	data_mem_model u_mem (.i_clock, .i_req(o_mem_req), .i_write(o_mem_write), .i_addr(o_mem_addr),
		.i_wdata(o_mem_wdata), .i_strobe(o_mem_strobe), .o_rdata(i_mem_rdata));
	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input string name, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// One instruction for one edge; valid stays up so a next call never re-drives it
	// in the same step; callers lower it before letting an idle edge pass
	task automatic run(input exec_pkg::exec_op_t op);
		i_op = op;
		i_valid = 1'b1;
		@(posedge i_clock);
		#1;
	endtask : run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	// ****************
	// Scenarios
	// ****************
	// Every size, byte lanes 0, 2 and 3, every shift amount; next load waits for write-back
	task automatic t_loads();
		exec_pkg::mem_size_t sz [8] = '{exec_pkg::size_word_t_w, exec_pkg::size_ubyte,
			exec_pkg::size_sbyte, exec_pkg::size_ubyte, exec_pkg::size_sbyte,
			exec_pkg::size_uhalf, exec_pkg::size_shalf, exec_pkg::size_shalf};
		logic [31:0] ad [8] = '{32'h8, 32'h8, 32'h8, 32'hb, 32'ha, 32'ha, 32'ha, 32'h8};
		logic [31:0] ex [8] = '{32'h8c7f_f0a5, 32'ha5, 32'hffff_ffa5, 32'h8c, 32'h7f,
			32'h8c7f, 32'hffff_8c7f, 32'hffff_f0a5};
		u_mem.mem[2] = 32'h8c7f_f0a5;
		for (int k = 0; k < 8; k++) begin
			i_size = sz[k];
			i_left_shift_amount = k[1:0];
			i_base_register = ad[k] - (32'h1 << k[1:0]);
			run(exec_pkg::load_register_op);
			chk("load address", ad[k], o_mem_addr);
			i_valid = 1'b0;
			@(posedge i_clock);
			#1;
			chk("load data", ex[k], o_wb_data);
			chk("load wb", 32'h14, {27'h0, o_wb_valid, o_wb_index});
		end
		i_left_shift_amount = 2'h0;
	endtask : t_loads
	// Byte then halfword store back to back, then a signed store refused
	task automatic t_stores();
		u_mem.mem[4] = 32'hffff_ffff;
		u_mem.mem[5] = 32'hffff_ffff;
		i_base_register = 32'h10;
		i_size = exec_pkg::size_ubyte;
		i_dest_value = 32'h1234_56c3;
		run(exec_pkg::store_register_op);
		i_offset_or_target_register = 32'h6;
		i_size = exec_pkg::size_uhalf;
		i_dest_value = 32'h5555_beef;
		run(exec_pkg::store_register_op);
		chk("store byte", 32'hffff_c3ff, u_mem.mem[4]);
		i_size = exec_pkg::size_sbyte;
		run(exec_pkg::store_register_op);
		chk("store half", 32'hbeef_ffff, u_mem.mem[5]);
		chk("signed store", 32'h2, {30'h0, o_illegal, o_mem_req});
	endtask : t_stores
	// Carry, borrow and overflow corners of both compares, then refusals
	task automatic t_compare();
		logic [31:0] a [7] = '{32'h5, 32'h0, 32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff, 0, 0};
		logic [31:0] b [7] = '{32'h5, 32'h1, 32'h1, 32'h1, 32'h2, 0, 0};
		logic [4:0]  f [7] = '{5'h6, 5'h8, 5'h3, 5'h9, 5'h2, 5'h12, 5'h12};
		for (int k = 0; k < 7; k++) begin
			i_base_register = a[k];
			i_second_operand = b[k];
			i_base_index = k == 5 ? exec_pkg::PC_INDEX : 4'h1;
			i_second_index = k == 6 ? exec_pkg::SP_INDEX : 4'h2;
			run(k < 3 || k == 5 ? exec_pkg::compare_op : exec_pkg::compare_negative_op);
			chk("flags", {27'h0, f[k]}, {27'h0, o_illegal, o_flags_nzcv});
			chk("compare wb", 32'h0, {31'h0, o_wb_valid | o_mem_req});
		end
		i_second_index = 4'h2;
	endtask : t_compare
	// Field clear and insert at the edges of the word, then a bad field and a stack pointer destination
	task automatic t_bitfield();
		logic [4:0]  l [6] = '{5'h8, 5'h8, 5'h0, 5'h1f, 5'h4, 5'h4};
		logic [5:0]  w [6] = '{6'hc, 6'hc, 6'h20, 6'h1, 6'h1d, 6'h1c};
		logic [31:0] e [6] = '{32'hfff0_00ff, 32'h000a_bc00, 32'h1234_5678, 32'h7fff_ffff, 0, 0};
		for (int k = 0; k < 6; k++) begin
			i_lsb = l[k];
			i_width = w[k];
			i_dest_value = k == 1 || k == 2 ? 32'h0 : 32'hffff_ffff;
			i_second_operand = k == 1 ? 32'hffff_fabc : 32'h1234_5678;
			i_rd_index = k == 5 ? exec_pkg::SP_INDEX : 4'h4;
			run(k[0] ^ k[1] ? exec_pkg::bitfield_insert_op : exec_pkg::bitfield_clear_op);
			chk("wb valid", {31'h0, k < 4}, {31'h0, o_wb_valid});
			if (k < 4)
				chk("bitfield", e[k], o_wb_data);
			chk("flags kept", 32'h2, {28'h0, o_flags_nzcv});
		end
		i_rd_index = 4'h4;
	endtask : t_bitfield
	// All four extend kinds across all four rotations
	task automatic t_extend();
		logic [4:0]  o [8] = '{5'h07, 5'h08, 5'h07, 5'h09, 5'h0a, 5'h09, 5'h0a, 5'h08};
		logic [31:0] e [8] = '{32'h1, 32'h80, 32'hffff_ff80, 32'hffff_ff7f, 32'h80ff,
			32'hffff_80ff, 32'h7f01, 32'hff};
		i_offset_or_target_register = 32'h80ff_7f01;
		for (int k = 0; k < 8; k++) begin
			i_rotate_sel = 2'(32'h8a7c >> (2 * k));
			run(exec_pkg::exec_op_t'(o[k]));
			chk("extend", e[k], o_wb_data);
		end
	endtask : t_extend
	// Indirect, immediate and zero-test branches including reach limits
	task automatic t_branch();
		logic [4:0]  op [15] = '{5'h0c, 5'h0b, 5'h0b, 5'h0b, 5'h0b, 5'h0b, 5'h0c, 5'h0f,
			5'h0f, 5'h10, 5'h10, 5'h0f, 5'h0f, 5'h0f, 5'h0f};
		logic [31:0] of [15] = '{32'hff00_0000, 32'h000f_fffc, 32'h0010_0000, 32'h0010_0000,
			32'h00ff_fffe, 32'h0100_0000, 32'h10, 32'h4, 32'h4, 32'h82, 32'h82, 32'h84,
			32'h4, 32'h4, 32'h2};
		logic [14:0] cnd = 15'h204e, inb = 15'h2008, ill = 15'h7864, tkn = 15'h029b;
		i_pc = 32'h0200_0000;
		i_offset_or_target_register = 32'h0000_1235;
		run(exec_pkg::indirect_branch_with_link_op);
		chk("indirect", 32'h1234, o_branch_target);
		chk("link", 32'h0200_0004, o_link_register);
		i_offset_or_target_register = 32'h0000_1234;
		run(exec_pkg::register_indirect_branch_op);
		chk("usage fault", 32'h2, {30'h0, o_usage_fault_a, o_branch_taken});
		for (int k = 0; k < 15; k++) begin
			i_conditional = cnd[k];
			i_in_cond_block = inb[k];
			i_second_index = k == 12 ? 4'h8 : 4'h3;
			i_second_operand = k == 8 || k == 9 ? 32'h5 : 32'h0;
			i_branch_offset = of[k];
			run(exec_pkg::exec_op_t'(op[k]));
			chk("branch", {30'h0, ill[k], tkn[k]}, {30'h0, o_illegal, o_branch_taken});
			if (tkn[k])
				chk("target", i_pc + of[k], o_branch_target);
			if (k == 0)
				chk("link", 32'h0200_0004, o_link_register);
			if (k == 0)
				chk("link valid", 32'h1, {31'h0, o_link_valid});
		end
	endtask : t_branch
	// ****************
	// Sequence and watchdog
	// ****************
	initial begin
		repeat (3) @(posedge i_clock);
		#1;
		chk("reset", 32'h0, {24'h0, o_mem_req, o_wb_valid, o_branch_taken, o_illegal, o_flags_nzcv});
		i_reset_n = 1'b1;
		t_loads();
		t_stores();
		t_compare();
		t_bitfield();
		t_extend();
		t_branch();
		finish_test();
	end
	initial begin
		repeat (2000) @(posedge i_clock);
		n_errors++;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
